// File: design/bit_sync.v
// Two-flop synchroniser for a group of independent asynchronous levels
`timescale 1ns/1ns
module bit_sync #(
    parameter WIDTH     = 1,
    parameter RESET_VAL = 0
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Levels
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] stable_ff;

    // First stage feeds only the second stage
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff   <= RESET_VAL[WIDTH-1:0];
            stable_ff <= RESET_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_ff   <= async_in;
            stable_ff <= meta_ff;
        end
    end

    assign sync_out = stable_ff;
endmodule // bit_sync

// File: design/dac_frame_regs.vh
// Constants for the DAC serial frame decoder: frame fields, codes, APB map and timing
`ifndef DAC_FRAME_REGS_VH
`define DAC_FRAME_REGS_VH

// Frame layout, most significant bit first
`define FRAME_BITS      24
`define FRAME_CRC_BITS  32
`define FR_MODE         23:22
`define FR_ADDR         21:16
`define FR_CHAN         20:16
`define FR_DATA         15:0
`define FR_WORD         31:8
`define FR_CRC          7:0

// Mode field values
`define MODE_INPUT      2'b11
`define MODE_OFFSET     2'b10
`define MODE_GAIN       2'b01
`define MODE_SPECIAL    2'b00

// Special-function codes
`define SF_NOP          6'h00
`define SF_CTRL_WR      6'h01
`define SF_READ_SEL     6'h05

// Readback operand layout and register kinds
`define RB_KIND         15:13
`define RB_ADDR         12:7
`define RB_GRP_HI       11
`define RB_CHAN         9:7
`define RB_INPUT_A      3'h1
`define RB_INPUT_B      3'h2
`define RB_OFFSET       3'h3
`define RB_GAIN         3'h4
`define RB_CTRL         3'h5

// Channel address decode
`define GRP_BROADCAST   2'b00
`define GRP_ZERO        2'b01
`define GRP_ONE         2'b10
`define SUB_ALL         3'h0
`define SUB_GRP0        3'h1
`define SUB_GRP1        3'h2
`define MASK_ALL        16'hFFFF
`define MASK_GRP0       16'h00FF
`define MASK_GRP1       16'hFF00
`define MASK_CH0        16'h0001
`define MASK_CH8        16'h0100

// Control register bits
`define CTRL_LOW        2:0
`define CTRL_ISEL       2
`define CTRL_CRCERR     3

// CRC-8, generator x^8+x^2+x+1
`define CRC_POLY        8'h07
`define CRC_INIT        8'h00

// Reset values, mid-scale point and 14-bit data mask
`define GAIN_RESET      16'hFFFF
`define OFFSET_RESET    16'h8000
`define MID_SCALE       16'h8000
`define MASK_14BIT      16'hFFFC

// APB map (byte addresses)
`define APB_CTRL        8'h00
`define APB_STATUS      8'h04
`define APB_FRAMES      8'h08
`define ST_BUSY         0
`define ST_RD_ARMED     1
`define ST_RD_ACTIVE    2
`define ST_CRCERR       3
`define ST_LAST_LEN     13:8

// Timing
`define CLK_NS          10
`define T_STAGE_NS      600
`define T_FINAL_NS      300

`endif

// File: design/dac_serial_frame_decoder.v
// Serial frame decoder of a 16-channel DAC with APB status registers
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "dac_frame_regs.vh"
module dac_serial_frame_decoder #(
    parameter DATA_BITS = 16,
    parameter CHANNELS  = 16
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Serial link
    input  wire        sync_n,
    input  wire        sclk,
    input  wire        sdi,
    output wire        sdo,
    output wire        sdo_oe_n,
    // Error pin
    output wire        crc_error_out_n
);
    // Low bits forced to zero on the narrow variant
    localparam [15:0] DATA_MASK = (DATA_BITS == 14) ? `MASK_14BIT : 16'hFFFF;
    localparam [5:0]  LEN_24    = `FRAME_BITS;
    localparam [5:0]  LEN_32    = `FRAME_CRC_BITS;
    localparam [5:0]  LEN_MAX   = 6'h21;
    localparam [5:0]  LEN_ONE   = 6'h01;

    // Per-channel storage
    reg [15:0] input_reg_a [0:CHANNELS-1];
    reg [15:0] input_reg_b [0:CHANNELS-1];
    reg [15:0] offset_reg  [0:CHANNELS-1];
    reg [15:0] gain_reg    [0:CHANNELS-1];
    reg [15:0] scaled_reg_a [0:CHANNELS-1];
    reg [15:0] scaled_reg_b [0:CHANNELS-1];

    // Link state
    reg        sync_d_ff;
    reg        sclk_d_ff;
    reg [31:0] shift_ff;
    reg [5:0]  len_ff;
    reg [5:0]  last_len_ff;
    reg [23:0] tx_ff;
    reg        rd_armed_ff;
    reg        rd_active_ff;
    reg [15:0] rd_sel_ff;
    reg [2:0]  ctrl_low_ff;
    reg        ctrl_crc_error_flag;
    reg [31:0] frames_ff;
    reg [31:0] prdata_ff;
    reg [15:0] rd_value;

    wire [2:0] link_s;
    wire       sync_s = link_s[2];
    wire       sclk_s = link_s[1];
    wire       sdi_s  = link_s[0];

    // All link inputs are asynchronous to pclk; frame select idles high
    bit_sync #(.WIDTH(3), .RESET_VAL(6)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({sync_n, sclk, sdi}),
        .sync_out (link_s)
    );

    // Edges seen on the synchronised link
    wire frame_fall = sync_d_ff & ~sync_s;
    wire frame_rise = ~sync_d_ff & sync_s;
    wire sclk_fall  = sclk_d_ff & ~sclk_s & ~sync_s;
    wire sclk_rise  = ~sclk_d_ff & sclk_s & ~sync_s;

    // CRC-8 over the frame word, MSB first from a zero remainder
    function [7:0] crc8;
        input [23:0] w;
        integer k;
        reg [7:0] c;
        begin
            c = `CRC_INIT;
            for (k = 23; k >= 0; k = k - 1)
                c = {c[6:0], 1'b0} ^ ((c[7] ^ w[k]) ? `CRC_POLY : 8'h00);
            crc8 = c;
        end
    endfunction

    // Channel address to a mask of target channels
    function [15:0] dec_mask;
        input [4:0] a;
        begin
            case (a[4:3])
                `GRP_BROADCAST:
                    case (a[2:0])
                        `SUB_ALL:  dec_mask = `MASK_ALL;
                        `SUB_GRP0: dec_mask = `MASK_GRP0;
                        `SUB_GRP1: dec_mask = `MASK_GRP1;
                        default:   dec_mask = 16'h0000;
                    endcase
                `GRP_ZERO: dec_mask = `MASK_CH0 << a[2:0];
                `GRP_ONE:  dec_mask = `MASK_CH8 << a[2:0];
                default:   dec_mask = 16'h0000;
            endcase
        end
    endfunction

    // Simple calibration: input times gain over full scale plus offset about mid-scale
    function [15:0] scale;
        input [15:0] x;
        input [15:0] m;
        input [15:0] c;
        reg [32:0] p;
        begin
            p     = {17'h00000, x} * {16'h0000, m + 17'h00001};
            scale = p[31:16] + c - `MID_SCALE;
        end
    endfunction

    // Frame decode at the frame select rise
    wire [23:0] word      = (len_ff == LEN_32) ? shift_ff[`FR_WORD] : shift_ff[23:0];
    wire        crc_ok    = (crc8(shift_ff[`FR_WORD]) == shift_ff[`FR_CRC]);
    wire        len_ok    = (len_ff == LEN_24) || ((len_ff == LEN_32) && crc_ok);
    wire        crc_bad   = frame_rise && (len_ff == LEN_32) && !crc_ok;
    wire        commit    = frame_rise && len_ok;
    wire [1:0]  mode      = word[`FR_MODE];
    wire [15:0] data_in   = word[`FR_DATA] & DATA_MASK;
    wire [15:0] tgt_mask  = dec_mask(word[`FR_CHAN]);
    wire        wr_data   = commit && (mode != `MODE_SPECIAL);
    wire        wr_ctrl   = commit && (mode == `MODE_SPECIAL) && (word[`FR_ADDR] == `SF_CTRL_WR);
    wire        wr_rdsel  = commit && (mode == `MODE_SPECIAL) && (word[`FR_ADDR] == `SF_READ_SEL);
    wire        rd_ctrl_done = frame_rise && rd_active_ff && (rd_sel_ff[`RB_KIND] == `RB_CTRL);
    wire        eng_busy;
    wire        calc_stb;
    wire [3:0]  calc_chan;
    wire [3:0]  rd_chan   = {rd_sel_ff[`RB_GRP_HI], rd_sel_ff[`RB_CHAN]};      // Group 10 maps to channels 8-15

    // Shift register and bit count; extra falls past 33 stop counting
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_d_ff   <= 1'b1;
            sclk_d_ff   <= 1'b1;                                              // Idle level, so no false edge
            shift_ff    <= 32'h00000000;
            len_ff      <= 6'h00;
            last_len_ff <= 6'h00;
        end
        else
        begin
            sync_d_ff <= sync_s;
            sclk_d_ff <= sclk_s;
            if (frame_fall)
                len_ff <= 6'h00;
            else if (sclk_fall)
            begin
                shift_ff <= {shift_ff[30:0], sdi_s};
                if (len_ff != LEN_MAX)
                    len_ff <= len_ff + LEN_ONE;
            end
            if (frame_rise)
                last_len_ff <= len_ff;
        end
    end

    // Register writes; a group write lands in every addressed channel
    integer i;
    always @(posedge pclk)
    begin
        for (i = 0; i < CHANNELS; i = i + 1)
        begin
            if (!presetn)
            begin
                input_reg_a[i] <= 16'h0000;
                input_reg_b[i] <= 16'h0000;
                offset_reg[i]  <= `OFFSET_RESET;
                gain_reg[i]    <= `GAIN_RESET;
            end
            else if (wr_data && tgt_mask[i])
            begin
                case (mode)
                    `MODE_INPUT:
                        if (ctrl_low_ff[`CTRL_ISEL])
                            input_reg_b[i] <= data_in;
                        else
                            input_reg_a[i] <= data_in;
                    `MODE_OFFSET: offset_reg[i] <= data_in;
                    `MODE_GAIN:   gain_reg[i]   <= data_in;
                    default:      offset_reg[i] <= offset_reg[i];
                endcase
            end
        end
    end

    // Scaled values recomputed one channel per stage-one slot
    always @(posedge pclk)
    begin
        if (calc_stb)
        begin
            scaled_reg_a[calc_chan] <= scale(input_reg_a[calc_chan], gain_reg[calc_chan], offset_reg[calc_chan]);
            scaled_reg_b[calc_chan] <= scale(input_reg_b[calc_chan], gain_reg[calc_chan], offset_reg[calc_chan]);
        end
    end

    // Calculation pacing; the host is expected to respect the busy time
    scale_engine #(.CHANNELS(CHANNELS), .CNT_W(8)) u_engine (
        .pclk       (pclk),
        .presetn    (presetn),
        .start      (wr_data),
        .start_mask (tgt_mask),
        .busy       (eng_busy),
        .calc_stb   (calc_stb),
        .calc_chan  (calc_chan)
    );

    // Readback value selection; scaled registers are never offered
    always @*
    begin
        case (rd_sel_ff[`RB_KIND])
            `RB_INPUT_A: rd_value = input_reg_a[rd_chan] & DATA_MASK;
            `RB_INPUT_B: rd_value = input_reg_b[rd_chan] & DATA_MASK;
            `RB_OFFSET:  rd_value = offset_reg[rd_chan] & DATA_MASK;
            `RB_GAIN:    rd_value = gain_reg[rd_chan] & DATA_MASK;
            `RB_CTRL:    rd_value = {12'h000, ctrl_crc_error_flag, ctrl_low_ff};
            default:     rd_value = 16'h0000;
        endcase
    end

    // Control bits, CRC flag and readback sequencing
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_low_ff         <= 3'h0;
            ctrl_crc_error_flag <= 1'b0;
            rd_armed_ff         <= 1'b0;
            rd_active_ff        <= 1'b0;
            rd_sel_ff           <= 16'h0000;
            tx_ff               <= 24'h000000;
            frames_ff           <= 32'h00000000;
        end
        else
        begin
            // Serial control write wins over a same-cycle APB write
            if (wr_ctrl)
                ctrl_low_ff <= word[`CTRL_LOW];
            else if (psel && penable && pwrite && (paddr == `APB_CTRL))
                ctrl_low_ff <= pwdata[`CTRL_LOW];
            // A new error beats the clear from a finishing readback
            if (crc_bad)
                ctrl_crc_error_flag <= 1'b1;
            else if (rd_ctrl_done)
                ctrl_crc_error_flag <= 1'b0;
            if (commit)
                frames_ff <= frames_ff + 32'h00000001;
            // Next frame carries the data out, MSB first
            if (frame_fall && rd_armed_ff)
            begin
                tx_ff        <= {8'h00, rd_value};
                rd_active_ff <= 1'b1;
                rd_armed_ff  <= 1'b0;
            end
            else if (sclk_rise && rd_active_ff)
                tx_ff <= {tx_ff[22:0], 1'b0};
            if (frame_rise && rd_active_ff)
                rd_active_ff <= 1'b0;
            if (wr_rdsel)
            begin
                rd_sel_ff   <= word[`FR_DATA];
                rd_armed_ff <= 1'b1;
            end
        end
    end

    assign sdo             = tx_ff[23];
    assign sdo_oe_n        = ~(rd_armed_ff | rd_active_ff);
    assign crc_error_out_n = ~ctrl_crc_error_flag;

    // APB read data captured in the setup phase; zero wait states
    wire apb_mapped = (paddr == `APB_CTRL) || (paddr == `APB_STATUS) || (paddr == `APB_FRAMES);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_ff <= 32'h00000000;
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                `APB_CTRL:   prdata_ff <= {28'h0000000, ctrl_crc_error_flag, ctrl_low_ff};
                `APB_STATUS: prdata_ff <= {18'h00000, last_len_ff, 4'h0, ctrl_crc_error_flag,
                                           rd_active_ff, rd_armed_ff, eng_busy};
                `APB_FRAMES: prdata_ff <= frames_ff;
                default:     prdata_ff <= 32'h00000000;
            endcase
        end
    end

    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !apb_mapped;
endmodule // dac_serial_frame_decoder

// File: design/scale_engine.v
// Sequencer that paces the three-stage scaling calculation channel by channel
`timescale 1ns/1ns
`include "dac_frame_regs.vh"
module scale_engine #(
    parameter CHANNELS = 16,
    parameter CNT_W    = 8
) (
    // Clock and reset
    input  wire                pclk,
    input  wire                presetn,
    // Request
    input  wire                start,
    input  wire [CHANNELS-1:0] start_mask,
    // Progress
    output wire                busy,
    output reg                 calc_stb,
    output reg  [3:0]          calc_chan
);
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_STAGE = 3'b010;
    localparam [2:0] ST_TAIL  = 3'b100;
    // Longest times round down to whole cycles
    localparam integer     STAGE_INT = `T_STAGE_NS / `CLK_NS;
    localparam integer     TAIL_INT  = (`T_STAGE_NS + `T_FINAL_NS) / `CLK_NS;
    localparam [CNT_W-1:0] STAGE_CYC = STAGE_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] TAIL_CYC  = TAIL_INT[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE   = 1;

    reg [2:0]          state_ff;
    reg [CNT_W-1:0]    cnt_ff;
    reg [CHANNELS-1:0] pend_ff;

    // Lowest pending channel is calculated first
    function [3:0] lowest;
        input [CHANNELS-1:0] m;
        integer k;
        begin
            lowest = 4'h0;
            for (k = CHANNELS - 1; k >= 0; k = k - 1)
                if (m[k])
                    lowest = k[3:0];
        end
    endfunction

    assign busy = (state_ff != ST_IDLE);

    // Stage one repeats per channel, then stages two and three run once
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= {CNT_W{1'b0}};
            pend_ff   <= {CHANNELS{1'b0}};
            calc_stb  <= 1'b0;
            calc_chan <= 4'h0;
        end
        else
        begin
            calc_stb <= 1'b0;
            case (state_ff)
                ST_IDLE:
                begin
                    if (start && (start_mask != {CHANNELS{1'b0}}))
                    begin
                        pend_ff  <= start_mask;
                        cnt_ff   <= STAGE_CYC;
                        state_ff <= ST_STAGE;
                    end
                end
                ST_STAGE:
                begin
                    if (cnt_ff == CNT_ONE)
                    begin
                        calc_stb  <= 1'b1;
                        calc_chan <= lowest(pend_ff);
                        // A late request joins the running batch
                        if ((pend_ff & ~(`MASK_CH0 << lowest(pend_ff))) == {CHANNELS{1'b0}} &&
                            !(start && (start_mask != {CHANNELS{1'b0}})))
                        begin
                            pend_ff  <= {CHANNELS{1'b0}};
                            cnt_ff   <= TAIL_CYC;
                            state_ff <= ST_TAIL;
                        end
                        else
                        begin
                            pend_ff <= (pend_ff & ~(`MASK_CH0 << lowest(pend_ff))) |
                                       (start ? start_mask : {CHANNELS{1'b0}});
                            cnt_ff  <= STAGE_CYC;
                        end
                    end
                    else
                    begin
                        cnt_ff <= cnt_ff - CNT_ONE;
                        if (start)
                            pend_ff <= pend_ff | start_mask;
                    end
                end
                ST_TAIL:
                begin
                    if (start && (start_mask != {CHANNELS{1'b0}}))
                    begin
                        pend_ff  <= start_mask;
                        cnt_ff   <= STAGE_CYC;
                        state_ff <= ST_STAGE;
                    end
                    else if (cnt_ff == CNT_ONE)
                        state_ff <= ST_IDLE;
                    else
                        cnt_ff <= cnt_ff - CNT_ONE;
                end
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // scale_engine

// File: verification/dac_host_model.sv
// Serial host model: sends frames and captures readback bits
`timescale 1ns/1ns
module dac_host_model (
    // Pacing clock of the host
    input  wire logic pclk,
    // Serial link
    output logic      sync_n,
    output logic      sclk,
    output logic      sdi,
    input  wire logic sdo
);
    // Idle: frame deselected, clock parked high
    initial
    begin
        sync_n = 1'b1;
        sclk   = 1'b1;
        sdi    = 1'b0;
    end

    // Sends the top n bits of w MSB first; sdo is sampled at each fall
    // Every change is made just after a pclk edge; 8 pclk per half period gives 160 ns
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        @(posedge pclk);
        sync_n <= 1'b0;
        for (int i = 31; i > 31 - n; i--)
        begin
            sdi <= w[i];
            repeat (8) @(posedge pclk);
            sclk <= 1'b0;
            r = {r[30:0], sdo};
            repeat (8) @(posedge pclk);
            sclk <= 1'b1;
        end
        repeat (8) @(posedge pclk);
        sync_n <= 1'b1;
        sdi <= ~sdi; // Released line must not keep the last bit
        repeat (200) @(posedge pclk); // Leaves room for a one-channel calculation
    endtask
endmodule // dac_host_model

// File: verification/dac_serial_frame_decoder_checker.sv
// Checker of APB and serial link behaviour at the decoder ports
`timescale 1ns/1ns
module dac_frame_checker (
    // Clock and reset
    input wire        pclk,
    input wire        presetn,
    // APB
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] prdata,
    input wire        pslverr,
    // Serial link
    input wire        sync_n,
    input wire        sclk,
    input wire        sdo,
    input wire        sdo_oe_n,
    input wire        crc_error_out_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc    = psel && penable;
    wire mapped = paddr == 8'h00 || paddr == 8'h04 || paddr == 8'h08;

    // Frame select high now, low eight cycles ago: a frame just ended
    sequence s_end;
        sync_n && !$past(sync_n, 8);
    endsequence
    // Clock fall while the device drives data out
    sequence s_rd_fall;
        $fell(sclk) && !sdo_oe_n;
    endsequence

    property p_slverr; acc && !mapped |-> pslverr; endproperty
    property p_okay; acc && mapped |-> !pslverr; endproperty
    property p_prdata; $changed(prdata) |-> $past(psel && !penable && !pwrite); endproperty
    property p_oe_on; $fell(sdo_oe_n) |-> s_end; endproperty
    property p_oe_off; $rose(sdo_oe_n) |-> s_end; endproperty
    property p_err_set; $fell(crc_error_out_n) |-> s_end; endproperty
    property p_err_clr; $rose(crc_error_out_n) |-> s_end; endproperty
    // Data out must not move around the host's sampling fall
    property p_sdo_hold; s_rd_fall |-> $stable(sdo) [*4]; endproperty

    a_slverr: assert property (p_slverr) else $error("no error on unmapped access");
    a_okay: assert property (p_okay) else $error("error on mapped access");
    a_prdata: assert property (p_prdata) else $error("read data moved without read setup");
    a_oe_on: assert property (p_oe_on) else $error("data out enabled off frame end");
    a_oe_off: assert property (p_oe_off) else $error("data out released off frame end");
    a_err_set: assert property (p_err_set) else $error("error pin fell off frame end");
    a_err_clr: assert property (p_err_clr) else $error("error pin rose off frame end");
    a_sdo_hold: assert property (p_sdo_hold) else $error("data out moved near clock fall");
endmodule // dac_frame_checker

bind dac_serial_frame_decoder dac_frame_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .sync_n(sync_n),
    .sclk(sclk), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .crc_error_out_n(crc_error_out_n));

// File: verification/test_dac_serial_frame_decoder.sv
// Self-checking bench for the DAC serial frame decoder
`timescale 1ns/1ns
`include "dac_frame_regs.vh"
module test_dac_serial_frame_decoder;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] rd;
    logic        er;
    wire  [31:0] prdata;
    wire         pready, pslverr, sync_n, sclk, sdi, sdo, sdo_oe_n, err_n;
    int          fails, total_checks, cycles;
    int          lens [3] = '{23, 25, 31};

    always #5 pclk = ~pclk;

    dac_serial_frame_decoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sync_n(sync_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n), .crc_error_out_n(err_n));
    dac_host_model host (.pclk(pclk), .sync_n(sync_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            final_report;
        end
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // APB transfer: setup, then access held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [7:0] crc8(input logic [23:0] w);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction

    // Frame of n bits; bad flips check bits to corrupt the CRC
    task wf(input logic [23:0] w, input int n, input logic [7:0] bad);
        logic [31:0] r;
        host.xfer({w, crc8(w) ^ bad}, n, r);
    endtask

    // Readback: select frame, then a no-op frame that shifts data out
    task rb(input logic [2:0] k, input logic [5:0] a, input logic [15:0] exp);
        logic [31:0] r;
        wf({`MODE_SPECIAL, `SF_READ_SEL, k, a, 7'h00}, 24, 8'h00);
        host.xfer(32'h0, 24, r);
        chk("readback", {16'h0000, exp}, r);
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        apb(1'b1, `APB_CTRL, 32'h0000000D);
        apb(1'b0, `APB_CTRL, 32'h0);
        chk("ctrl", 32'h00000005, rd);
        apb(1'b1, `APB_CTRL, 32'h0);
        apb(1'b0, `APB_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        rb(`RB_OFFSET, 6'h08, 16'h8000);
        rb(`RB_GAIN, 6'h08, 16'hFFFF);
        wf({`MODE_INPUT, 6'h0B, 16'h1234}, 24, 8'h00);
        rb(`RB_INPUT_A, 6'h0B, 16'h1234);
        foreach (lens[i])
            wf({`MODE_INPUT, 6'h0B, 16'hDEAD}, lens[i], 8'h00);
        apb(1'b0, `APB_STATUS, 32'h0);
        chk("status", 32'h00001F00, rd);
        rb(`RB_INPUT_A, 6'h0B, 16'h1234);
        wf({`MODE_INPUT, 6'h0B, 16'h0F0F}, 32, 8'h00);
        rb(`RB_INPUT_A, 6'h0B, 16'h0F0F);
        wf({`MODE_INPUT, 6'h0B, 16'hAAAA}, 32, 8'h01);
        chk("error pin", 32'h0, {31'h0, err_n});
        apb(1'b0, `APB_CTRL, 32'h0);
        chk("ctrl", 32'h8, rd);
        rb(`RB_INPUT_A, 6'h0B, 16'h0F0F);
        rb(`RB_CTRL, 6'h00, 16'h0008);
        chk("error pin", 32'h1, {31'h0, err_n});
        wf({`MODE_SPECIAL, `SF_CTRL_WR, 16'h0004}, 24, 8'h00);
        wf({`MODE_INPUT, 6'h0B, 16'h5678}, 24, 8'h00);
        rb(`RB_INPUT_B, 6'h0B, 16'h5678);
        rb(`RB_INPUT_A, 6'h0B, 16'h0F0F);
        wf({`MODE_OFFSET, 6'h12, 16'h1357}, 24, 8'h00);
        wf({`MODE_GAIN, 6'h12, 16'h2468}, 24, 8'h00);
        rb(`RB_OFFSET, 6'h12, 16'h1357);
        rb(`RB_GAIN, 6'h12, 16'h2468);
        wf({`MODE_INPUT, 6'h02, 16'h4242}, 24, 8'h00);
        apb(1'b0, `APB_STATUS, 32'h0);
        chk("status", 32'h00001801, rd);
        repeat (1000) @(posedge pclk); // Group write needs 600 ns per channel
        apb(1'b0, `APB_STATUS, 32'h0);
        chk("status", 32'h00001800, rd);
        rb(`RB_INPUT_B, 6'h11, 16'h4242);
        rb(`RB_INPUT_B, 6'h0B, 16'h5678);
        apb(1'b0, `APB_FRAMES, 32'h0);
        chk("frames", 32'h00000021, rd);
        final_report;
    end
endmodule // test_dac_serial_frame_decoder
